//--- logic/atc_top.sv
// Converter control: registers, triggers, sequencing and compare.
// Assumes an APB master on pclk and an analog core beside it.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module atc_top
    import atc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic        pclk,        // bus clock
    input  wire logic        presetn,     // async reset, low active
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction
    input  wire logic [11:0] paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic [31:0]      prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    input  wire logic        ext_ref_clock, // ext reference tick
    input  wire logic        lpo_tick,    // 32 kHz oscillator tick
    input  wire logic        async_tick,  // local async clock tick
    input  wire logic        alt_tick,    // alternate clock tick
    input  wire logic [1:0]  power_mode,  // run, wait or stop3
    input  wire logic        cmp_hi,      // analog comparator out
    output logic [9:0]       dac_code,    // trial code to DAC
    output logic [4:0]       channel_select, // analog mux select
    output logic [7:0]       analog_pin_enable_reg, // pin enables
    output logic             long_sample, // long sample requested
    output logic             bandgap_buffer_enable, // bandgap on
    output logic             conv_irq     // conversion interrupt
);
    logic [7:0]  status_ctrl_1;
    logic [7:0]  status_ctrl_2;
    logic [7:0]  cfg;
    logic [9:0]  cmp_value;
    logic [7:0]  power_mgmt_ctrl1;
    logic [7:0]  rtc_ctrl;
    logic [9:0]  result;
    logic        conv_complete_flag;
    logic        active;
    logic        wr;
    logic        rd;
    logic        wr_sc1;
    logic        rd_low;
    logic        overflow;
    logic        hw_conversion_trigger;
    logic        hw_start;
    logic        sw_start;
    logic        start;
    logic        relaunch;
    logic        ch_off;
    logic        allowed;
    logic        half_tog;
    logic        conv_tick;
    logic [1:0]  setup_cnt;
    logic        sar_start;
    logic        sar_done;
    logic [9:0]  sar_result;
    logic        cmp_true;
    logic [9:0]  shaped;
    logic        mode8;
    atc_access_t acc;

    assign acc.addr  = paddr;
    assign acc.write = psel && penable && pwrite;
    assign acc.read  = psel && penable && !pwrite;
    assign acc.wdata = pwdata[7:0];
    assign wr        = acc.write;
    assign rd        = acc.read;
    assign pready    = 1'b1;
    assign wr_sc1    = wr && acc.addr == OFS_SC1;
    assign rd_low    = rd && acc.addr == OFS_RES_LO;

    always_comb begin
        case (acc.addr)
            OFS_SC1, OFS_SC2, OFS_RES_HI, OFS_RES_LO, OFS_CMP_HI,
            OFS_CMP_LO, OFS_CFG, OFS_PIN_EN, OFS_PWR,
            OFS_RTC: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    assign channel_select        = status_ctrl_1[4:0];
    assign ch_off                = channel_select == CH_OFF;
    assign mode8                 = cfg[CFG_MODE_BIT];
    assign long_sample           = cfg[4];
    assign bandgap_buffer_enable = power_mgmt_ctrl1[PWR_BGBUF_BIT];

    // Stop3 keeps converting only with the low-volt stop enable set.
    assign allowed = power_mode != ATC_MODE_STP3
                     || power_mgmt_ctrl1[PWR_LVSTOP_BIT];

    // Only one pin enable register exists in this instance.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_pin_enable_reg <= 8'h00;
        end else if (wr && acc.addr == OFS_PIN_EN) begin
            analog_pin_enable_reg <= acc.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ctrl_1    <= SC1_RESET;
            status_ctrl_2    <= 8'h00;
            cfg              <= CFG_RESET;
            cmp_value        <= 10'h000;
            power_mgmt_ctrl1 <= PWR_RESET;
            rtc_ctrl         <= RTC_RESET;
        end else if (wr) begin
            case (acc.addr)
                OFS_SC1:    status_ctrl_1 <= {1'b0, acc.wdata[6:0]};
                OFS_SC2:    status_ctrl_2 <= {1'b0, acc.wdata[6:4], 4'h0};
                OFS_CFG:    cfg <= acc.wdata;
                OFS_CMP_HI: cmp_value[9:8] <= acc.wdata[1:0];
                OFS_CMP_LO: cmp_value[7:0] <= acc.wdata;
                OFS_PWR:    power_mgmt_ctrl1 <= acc.wdata;
                OFS_RTC:    rtc_ctrl <= acc.wdata;
                default:    status_ctrl_2 <= status_ctrl_2;
            endcase
        end
    end

    // Periodic counter keeps running in every power mode.
    atc_periodic #(
        .CNT_W (CNT_W)
    ) u_periodic (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (rtc_ctrl[RTC_EN_BIT]),
        .src_ext  (rtc_ctrl[RTC_SRC_BIT]),
        .ext_tick (ext_ref_clock),
        .lpo_tick (lpo_tick),
        .rate     (rtc_ctrl[3:0]),
        .overflow (overflow)
    );

    // The overflow is a registered pulse in this domain, one per period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_conversion_trigger <= 1'b0;
        end else begin
            hw_conversion_trigger <= overflow;
        end
    end

    assign hw_start = status_ctrl_2[SC2_HWT_BIT] && hw_conversion_trigger
                      && !active && !ch_off && allowed;
    assign sw_start = wr_sc1 && acc.wdata[4:0] != CH_OFF
                      && !status_ctrl_2[SC2_HWT_BIT];
    // A relaunch never outruns a disable or a fresh control write.
    assign start    = sw_start || hw_start
                      || (relaunch && !ch_off && !wr_sc1);

    // Conversion clock source selection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_tog <= 1'b0;
        end else begin
            half_tog <= ~half_tog;
        end
    end

    always_comb begin
        case (atc_clk_t'(cfg[1:0]))
            ATC_CLK_BUS:  conv_tick = 1'b1;
            ATC_CLK_HALF: conv_tick = half_tog;
            ATC_CLK_ALT:  conv_tick = alt_tick;
            ATC_CLK_ASYN: conv_tick = async_tick;
            default:      conv_tick = 1'b1;
        endcase
    end

    // Short sample phase before the bit decisions.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_cnt <= 2'd0;
            sar_start <= 1'b0;
        end else begin
            sar_start <= 1'b0;
            if (start) begin
                setup_cnt <= 2'(CONV_SETUP);
            end else if (setup_cnt != 2'd0 && conv_tick) begin
                setup_cnt <= setup_cnt - 2'd1;
                sar_start <= setup_cnt == 2'd1;
            end
        end
    end

    atc_sar #(
        .W (RES_BITS)
    ) u_sar (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (sar_start),
        .abort   (start || wr_sc1 || ch_off),
        .tick    (conv_tick && allowed),
        .cmp_hi  (cmp_hi),
        .guess   (dac_code),
        .result  (sar_result),
        .done    (sar_done)
    );

    // Right-justified result, optionally cut to eight bits.
    assign shaped = mode8 ? {2'b00, sar_result[9:2]}
                          : sar_result;

    always_comb begin
        if (status_ctrl_2[SC2_CFGT_BIT]) begin
            cmp_true = shaped >= cmp_value;
        end else begin
            cmp_true = shaped < cmp_value;
        end
    end

    // Active from start to completion or abort; single runs go idle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= 1'b0;
        end else if (start) begin
            active <= 1'b1;
        end else if (wr_sc1 || ch_off) begin
            active <= 1'b0;
        end else if (sar_done) begin
            active <= status_ctrl_1[SC1_CONT_BIT]
                      && !status_ctrl_2[SC2_HWT_BIT];
        end
    end

    // Continuous software mode restarts on completion.
    logic restart;
    assign restart = sar_done && status_ctrl_1[SC1_CONT_BIT]
                     && !status_ctrl_2[SC2_HWT_BIT] && !ch_off;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 10'h000;
        end else if (sar_done
                     && (!status_ctrl_2[SC2_CFE_BIT] || cmp_true)) begin
            result <= shaped;
        end
    end

    // Set wins over a same-cycle clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_complete_flag <= 1'b0;
        end else if (sar_done
                     && (!status_ctrl_2[SC2_CFE_BIT] || cmp_true)) begin
            conv_complete_flag <= 1'b1;
        end else if (wr_sc1 || rd_low) begin
            conv_complete_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_irq <= 1'b0;
        end else begin
            conv_irq <= conv_complete_flag && status_ctrl_1[SC1_IEN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_SC1:    prdata <= {24'h0, conv_complete_flag,
                                       status_ctrl_1[6:0]};
                OFS_SC2:    prdata <= {24'h0, active, status_ctrl_2[6:0]};
                OFS_RES_HI: prdata <= {30'h0, result[9:8]};
                OFS_RES_LO: prdata <= {24'h0, result[7:0]};
                OFS_CMP_HI: prdata <= {30'h0, cmp_value[9:8]};
                OFS_CMP_LO: prdata <= {24'h0, cmp_value[7:0]};
                OFS_CFG:    prdata <= {24'h0, cfg};
                OFS_PIN_EN: prdata <= {24'h0, analog_pin_enable_reg};
                OFS_PWR:    prdata <= {24'h0, power_mgmt_ctrl1};
                OFS_RTC:    prdata <= {24'h0, rtc_ctrl};
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Software continuous mode relaunches through the setup phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relaunch <= 1'b0;
        end else begin
            relaunch <= restart;
        end
    end
endmodule

//--- logic/atc_pkg.sv
// Constants, register map and shared types of the converter control block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package atc_pkg;

    localparam logic [11:0] OFS_SC1     = 12'h000;
    localparam logic [11:0] OFS_SC2     = 12'h004;
    localparam logic [11:0] OFS_RES_HI  = 12'h008;
    localparam logic [11:0] OFS_RES_LO  = 12'h00C;
    localparam logic [11:0] OFS_CMP_HI  = 12'h010;
    localparam logic [11:0] OFS_CMP_LO  = 12'h014;
    localparam logic [11:0] OFS_CFG     = 12'h018;
    localparam logic [11:0] OFS_PIN_EN  = 12'h01C;
    localparam logic [11:0] OFS_PWR     = 12'h020;
    localparam logic [11:0] OFS_RTC     = 12'h024;

    // Status and control one fields.
    localparam int SC1_FLAG_BIT = 7;
    localparam int SC1_IEN_BIT  = 6;
    localparam int SC1_CONT_BIT = 5;
    // Status and control two fields.
    localparam int SC2_ACT_BIT  = 7;
    localparam int SC2_HWT_BIT  = 6;
    localparam int SC2_CFE_BIT  = 5;
    localparam int SC2_CFGT_BIT = 4;
    // Configuration fields.
    localparam int CFG_MODE_BIT = 2;
    localparam int CFG_CLK_LSB  = 0;
    // Power control fields.
    localparam int PWR_LVSTOP_BIT = 0;
    localparam int PWR_BGBUF_BIT  = 1;
    // Periodic counter control fields.
    localparam int RTC_RATE_LSB = 0;
    localparam int RTC_SRC_BIT  = 4;
    localparam int RTC_EN_BIT   = 5;

    localparam logic [4:0] CH_OFF     = 5'h1F;
    localparam logic [7:0] SC1_RESET  = 8'h1F;
    localparam logic [7:0] CFG_RESET  = 8'h00;
    localparam logic [7:0] PWR_RESET  = 8'h00;
    localparam logic [7:0] RTC_RESET  = 8'h00;
    localparam int         RES_BITS   = 10;
    localparam int         CONV_SETUP = 2;

    typedef enum logic [1:0] {
        ATC_CLK_BUS  = 2'b00,
        ATC_CLK_HALF = 2'b01,
        ATC_CLK_ALT  = 2'b10,
        ATC_CLK_ASYN = 2'b11
    } atc_clk_t;

    typedef enum logic [1:0] {
        ATC_IDLE   = 2'b00,
        ATC_SAMPLE = 2'b01,
        ATC_CONV   = 2'b11,
        ATC_DONE   = 2'b10
    } atc_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic        read;
        logic [7:0]  wdata;
    } atc_access_t;

    typedef enum logic [1:0] {
        ATC_MODE_RUN  = 2'b00,
        ATC_MODE_WAIT = 2'b01,
        ATC_MODE_STP3 = 2'b10
    } atc_mode_t;

endpackage

//--- logic/atc_periodic.sv
// Free-running periodic counter that yields the hardware conversion trigger.
// Assumes both tick inputs are one-cycle enables synchronous to pclk.
`timescale 1ns/1ps
module atc_periodic
    import atc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic       pclk,       // bus clock
    input  wire logic       presetn,    // async reset, low active
    input  wire logic       enable,     // counter runs
    input  wire logic       src_ext,    // 1: ext reference tick
    input  wire logic       ext_tick,   // ext reference clock tick
    input  wire logic       lpo_tick,   // 32 kHz oscillator tick
    input  wire logic [3:0] rate,       // periodic rate select
    output logic            overflow    // one pulse per period
);
    logic [CNT_W-1:0] count;
    logic             tick;
    logic [CNT_W-1:0] limit;

    assign tick  = src_ext ? ext_tick : lpo_tick;

    always_comb begin
        limit = '0;
        limit[rate] = 1'b1;
    end

    // Counts while enabled and holds when disabled; the rate picks the wrap point.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count    <= '0;
            overflow <= 1'b0;
        end else begin
            overflow <= 1'b0;
            if (enable && tick) begin
                if (count >= limit - 1'b1) begin
                    count    <= '0;
                    overflow <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end
endmodule

//--- logic/atc_sar.sv
// Successive approximation sequencer, one bit decided per conversion tick.
// Assumes an analog comparator answers in the same cycle as the guess.
`timescale 1ns/1ps
module atc_sar
    import atc_pkg::*;
#(
    parameter int W = RES_BITS
) (
    input  wire logic         pclk,      // bus clock
    input  wire logic         presetn,   // async reset, low active
    input  wire logic         start,     // begin, aborts any run
    input  wire logic         abort,     // stop without result
    input  wire logic         tick,      // conversion clock enable
    input  wire logic         cmp_hi,    // analog above guess
    output logic [W-1:0]      guess,     // trial code to DAC
    output logic [W-1:0]      result,    // finished code
    output logic              done       // one pulse at end
);
    logic [W-1:0] mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guess  <= '0;
            mask   <= '0;
            result <= '0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                mask <= '0;
            end else if (start) begin
                mask  <= {1'b1, {(W-1){1'b0}}};
                guess <= {1'b1, {(W-1){1'b0}}};
            end else if (tick && mask != '0) begin
                if (!cmp_hi) begin
                    guess <= (guess & ~mask) | (mask >> 1);
                end else begin
                    guess <= guess | (mask >> 1);
                end
                mask <= mask >> 1;
                if (mask[0]) begin
                    result <= cmp_hi ? guess : (guess & ~mask);
                    done   <= 1'b1;
                end
            end
        end
    end
endmodule

//--- test/atc_chk.sv
// Concurrent checks on the ports of the converter control block.
// Assumes it is bound into atc_top and runs on its single bus clock.
`timescale 1ns/1ps
module atc_chk
    import atc_pkg::*;
(
    input wire logic        pclk,                  // bus clock
    input wire logic        presetn,               // async reset
    input wire logic        psel,                  // APB select
    input wire logic        penable,               // APB access phase
    input wire logic        pwrite,                // APB direction
    input wire logic [11:0] paddr,                 // APB byte address
    input wire logic [31:0] pwdata,                // APB write data
    input wire logic        pslverr,               // APB error
    input wire logic [4:0]  channel_select,        // analog mux select
    input wire logic [7:0]  analog_pin_enable_reg, // pin enables
    input wire logic        long_sample,           // long sample
    input wire logic        bandgap_buffer_enable, // bandgap on
    input wire logic        conv_irq               // conversion interrupt
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic acc;
    logic mapped;
    logic w_sc1;
    logic r_lo;
    assign acc    = psel && penable;
    assign mapped = paddr inside {OFS_SC1, OFS_SC2, OFS_RES_HI, OFS_RES_LO,
                    OFS_CMP_HI, OFS_CMP_LO, OFS_CFG, OFS_PIN_EN, OFS_PWR,
                    OFS_RTC};
    assign w_sc1  = acc && pwrite && paddr == OFS_SC1;
    assign r_lo   = acc && !pwrite && paddr == OFS_RES_LO;

    property p_chan;
        w_sc1 |=> channel_select == $past(pwdata[4:0]);
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel select not loaded by write");
    property p_pin;
        acc && pwrite && paddr == OFS_PIN_EN
            |=> analog_pin_enable_reg == $past(pwdata[7:0]);
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin enable register not loaded");
    property p_bg;
        acc && pwrite && paddr == OFS_PWR
            |=> bandgap_buffer_enable == $past(pwdata[PWR_BGBUF_BIT]);
    endproperty
    a_bg: assert property (p_bg)
        else $error("bandgap enable not loaded");
    property p_long;
        acc && pwrite && paddr == OFS_CFG
            |=> long_sample == $past(pwdata[4]);
    endproperty
    a_long: assert property (p_long)
        else $error("long sample not loaded");
    property p_err;
        acc |-> pslverr == !mapped;
    endproperty
    a_err: assert property (p_err)
        else $error("error response does not match address map");
    property p_wclr;
        w_sc1 |-> ##2 !conv_irq;
    endproperty
    a_wclr: assert property (p_wclr)
        else $error("interrupt stays after control write");
    property p_rclr;
        r_lo |-> ##2 !conv_irq;
    endproperty
    a_rclr: assert property (p_rclr)
        else $error("interrupt stays after low result read");
    property p_off;
        $rose(conv_irq) |-> $past(channel_select, 2) != CH_OFF;
    endproperty
    a_off: assert property (p_off)
        else $error("conversion completed while disabled");

    c_conv: cover property ($rose(conv_irq));
    c_err:  cover property (acc && pslverr);
    c_off:  cover property (w_sc1 && pwdata[4:0] == CH_OFF);
endmodule

bind atc_top atc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pslverr, .channel_select, .analog_pin_enable_reg,
    .long_sample, .bandgap_buffer_enable, .conv_irq);

//--- test/atc_top_tb.sv
// Self-checking bench for the converter control block.
// Assumes an ideal comparator: analog level at or above the trial code.
`timescale 1ns/1ps
module atc_top_tb
    import atc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        ext_ref_clock, lpo_tick, async_tick, alt_tick, cmp_hi;
    logic [1:0]  power_mode;
    logic [9:0]  dac_code, ana, av, cv;
    logic [4:0]  channel_select, ch;
    logic [7:0]  analog_pin_enable_reg, cfg;
    logic        long_sample, bandgap_buffer_enable, conv_irq, rerr, pm_go;
    int          num_errors, n_compared, cyc;

    assign cmp_hi = (ana >= dac_code);

    atc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_ref_clock, .lpo_tick, .async_tick,
        .alt_tick, .power_mode, .cmp_hi, .dac_code, .channel_select,
        .analog_pin_enable_reg, .long_sample, .bandgap_buffer_enable,
        .conv_irq);

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        async_tick <= 1'($urandom);
        alt_tick <= 1'($urandom);
        if (pm_go) begin
            power_mode <= 2'($urandom % 3);
        end
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_flag(input int n);
        repeat (n) begin
            apb(1'b0, OFS_SC1, 32'h0);
            if (rdat[SC1_FLAG_BIT] === 1'b1) break;
        end
    endtask

    task automatic chk_res(input logic [9:0] e);
        apb(1'b0, OFS_RES_HI, 32'h0);
        chk(rdat, 32'(e[9:8]));
        apb(1'b0, OFS_RES_LO, 32'h0);
        chk(rdat, 32'(e[7:0]));
    endtask

    function automatic logic [9:0] conv_val(input logic [9:0] a,
                                            input logic e8);
        return e8 ? {2'b00, a[9:2]} : a;
    endfunction

    initial begin
        void'($urandom(17573));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_ref_clock, lpo_tick, async_tick, alt_tick, pm_go} = '0;
        {num_errors, n_compared, cyc} = '0;
        power_mode = ATC_MODE_RUN;
        ana = 10'h000;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(32'(channel_select), 32'(CH_OFF));
        apb(1'b0, OFS_SC1, 32'h0);
        chk(rdat, 32'(SC1_RESET));
        apb(1'b0, OFS_CFG, 32'h0);
        chk(rdat, 32'(CFG_RESET));
        apb(1'b0, OFS_RTC, 32'h0);
        chk(rdat, 32'(RTC_RESET));
        apb(1'b0, 12'h028, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        apb(1'b1, OFS_PIN_EN, 32'h5A);
        @(negedge pclk);
        chk(32'(analog_pin_enable_reg), 32'h5A);
        // Low-volt stop enable goes first so stop3 may then be entered.
        apb(1'b1, OFS_PWR, 32'h3);
        @(negedge pclk);
        chk(32'(bandgap_buffer_enable), 32'h1);
        pm_go = 1'b1;
        for (int i = 0; i < 12; i++) begin
            ana <= 10'($urandom);
            ch = 5'($urandom % 31);
            cfg = 8'({i[0], 1'b0, i[2], i[1:0]});
            apb(1'b1, OFS_CFG, 32'(cfg));
            @(negedge pclk);
            chk(32'(long_sample), 32'(cfg[4]));
            apb(1'b1, OFS_SC1, 32'({2'b01, i == 5, ch}));
            wait_flag(60);
            @(negedge pclk);
            chk(32'(conv_irq), 32'h1);
            chk(32'(channel_select), 32'(ch));
            chk_res(conv_val(ana, cfg[2]));
            apb(1'b0, OFS_SC1, 32'h0);
            chk(rdat, 32'({2'b01, i == 5, ch}));
            if (i == 5) begin
                apb(1'b0, OFS_SC2, 32'h0);
                chk(32'(rdat[SC2_ACT_BIT]), 32'h1);
                apb(1'b1, OFS_SC1, 32'(CH_OFF));
            end
            apb(1'b0, OFS_SC2, 32'h0);
            chk(32'(rdat[SC2_ACT_BIT]), 32'h0);
        end
        apb(1'b1, OFS_CFG, 32'h0);
        for (int k = 0; k < 4; k++) begin
            av = 10'($urandom);
            ana <= av;
            cv = (k < 2) ? av : 10'($urandom);
            apb(1'b1, OFS_CMP_HI, 32'(cv[9:8]));
            apb(1'b1, OFS_CMP_LO, 32'(cv[7:0]));
            apb(1'b1, OFS_SC2, 32'({2'b00, 1'b1, k[0], 4'h0}));
            apb(1'b1, OFS_SC1, 32'h1);
            wait_flag(40);
            chk(32'(rdat[7]), 32'(k[0] ? av >= cv : av < cv));
        end
        apb(1'b1, OFS_SC2, 32'h0);
        ana <= 10'h3FF;
        apb(1'b1, OFS_SC1, 32'h2);
        repeat (4) @(posedge pclk);
        av = 10'($urandom);
        ana <= av;
        apb(1'b1, OFS_SC1, 32'h3);
        wait_flag(60);
        chk_res(av);
        apb(1'b1, OFS_SC1, 32'h3);
        wait_flag(60);
        apb(1'b1, OFS_SC1, 32'(CH_OFF));
        repeat (40) @(posedge pclk);
        apb(1'b0, OFS_SC1, 32'h0);
        chk(rdat, 32'(CH_OFF));
        apb(1'b0, OFS_SC2, 32'h0);
        chk(32'(rdat[SC2_ACT_BIT]), 32'h0);
        av = 10'($urandom);
        ana <= av;
        apb(1'b1, OFS_SC1, 32'h4);
        wait_flag(60);
        apb(1'b0, OFS_RES_LO, 32'h0);
        apb(1'b1, OFS_SC2, 32'h40);
        apb(1'b1, OFS_RTC, 32'h23);
        for (int p = 0; p < 8; p++) begin
            @(posedge pclk);
            lpo_tick <= 1'b1;
            @(posedge pclk);
            lpo_tick <= 1'b0;
            if (p == 6) begin
                repeat (30) @(posedge pclk);
                apb(1'b0, OFS_SC1, 32'h0);
                chk(32'(rdat[7]), 32'h0);
            end
        end
        wait_flag(40);
        chk_res(av);
        apb(1'b1, OFS_RTC, 32'h31);
        repeat (6) begin
            @(posedge pclk);
            ext_ref_clock <= 1'b1;
            @(posedge pclk);
            ext_ref_clock <= 1'b0;
        end
        wait_flag(40);
        chk(32'(rdat[7]), 32'h1);
        apb(1'b0, OFS_SC2, 32'h0);
        chk(32'(rdat[SC2_ACT_BIT]), 32'h0);
        summarize();
    end
endmodule
